// ===== logic/pwmwc_core.sv
// Six-channel waveform core with pairing, boundary cases and shutdown irq
// Functional notes
// - center_align_enable picks left or center mode
// - Left mode counts up, duty match toggles
// - Left period match resets, loads buffers
// - Left counter runs 0 to period-1
// - Center mode counts up/down, zero forces up
// - Center period match turns direction down
// - Center duty match toggles both directions
// - Center reaching zero counts up, loads buffers
// - Center period is twice period_value
// - High time follows polarity_select
// - Three bits join pairs 0/1, 2/3, 4/5
// - Lower channel holds high-order bytes
// - Pair uses odd channel polarity and pin
// - Pair enabled by odd bit, even output off
// - Any joined counter write resets sixteen bits
// - Pair uses odd channel alignment bit
// - Zero duty gives constant level by polarity
// - Zero period holds counter, constant level
// - Duty at or above period gives constant
// - Reset sets counters up, outputs and flag low
// - Interrupt only when shutdown_irq_enable set
// - Flag on pin change or arm while active
// - Polarity one starts high, zero starts low
// - Enabled writes buffered, disabled load directly
// - Counter write clears, ups, loads, sets output
`timescale 1ns/1ps
`include "pwmwc_defines.svh"

module pwmwc_core
  import pwmwc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Per-channel tick from the selected prescaled clock
  input  wire logic [5:0]       clock_tick,
  // Channel programming
  input  wire pwmwc_cfg_t [5:0] cfg,
  input  wire logic [5:0]       period_write,
  input  wire logic [5:0]       duty_write,
  // Pairing bits: 0 = ch0/1, 1 = ch2/3, 2 = ch4/5
  input  wire logic [2:0]       join_bits,
  // Shutdown controls
  input  wire logic             channel5_pin,
  input  wire logic             channel5_active_level,
  input  wire logic             emergency_shutdown_enable,
  input  wire logic             shutdown_arm_bit,
  input  wire logic             shutdown_irq_enable,
  input  wire logic             shutdown_flag_clear,
  // Results
  output logic      [5:0]       channel_output,
  output logic      [7:0]       channel_counter [6],
  output logic                  shutdown_irq_flag,
  output logic                  irq
);

  typedef struct packed {
    pwmwc_ch_t [5:0] ch;
    logic      [5:0] out;
    pwmwc_sdn_t      sdn;
  } pwmwc_state_t;

  pwmwc_state_t state_q;
  pwmwc_state_t state_d;

  // Whether an 8-bit slot belongs to a joined pair
  function automatic logic joined(input int i, input logic [2:0] jb);
    return jb[i/2];
  endfunction

  // Waveform level for one flip-flop, polarity and boundary case
  function automatic logic level(input logic [15:0] per,
                                 input logic [15:0] dty,
                                 input logic pol, input logic ff);
    if (per == 16'h0000)
      return pol;
    else if (dty == 16'h0000)
      return ~pol;
    else if (dty >= per)
      return pol;
    else
      return pol ? ~ff : ff;
  endfunction

  // Next state: a joined pair takes one 16-bit pass, a split pair one 8-bit pass per channel
  always_comb begin
    logic [15:0] cnt;
    logic [15:0] per;
    logic [15:0] dty;
    logic        en;
    logic        cae;
    logic        pol;
    logic        cw;
    logic        tk;
    logic        dn;
    logic        ff;
    int          lo;
    int          hi;
    logic        own_en;
    cnt = 16'h0000;
    per = 16'h0000;
    dty = 16'h0000;
    en  = 1'b0;
    cae = 1'b0;
    pol = 1'b0;
    cw  = 1'b0;
    tk  = 1'b0;
    dn  = 1'b0;
    ff  = 1'b0;
    lo  = 0;
    hi  = 0;
    own_en = 1'b0;
    state_d = state_q;
    // Buffer writes land in the active copy while the channel is idle
    for (int i = 0; i < `PWMWC_NUM_CH; i++) begin
      own_en = joined(i, join_bits) ? cfg[i | 1].channel_enable
                                    : cfg[i].channel_enable;
      if (period_write[i]) begin
        state_d.ch[i].per_buf = cfg[i].period_value;
        if (!own_en)
          state_d.ch[i].per_act = cfg[i].period_value;
      end
      if (duty_write[i]) begin
        state_d.ch[i].dty_buf = cfg[i].duty_value;
        if (!own_en)
          state_d.ch[i].dty_act = cfg[i].duty_value;
      end
    end
    for (int p = 0; p < `PWMWC_NUM_PAIRS; p++) begin
      for (int s = 0; s < 2; s++) begin
        hi = 2 * p;
        lo = 2 * p + 1;
        if (join_bits[p]) begin
          if (s == 0)
            continue;
          // Even slot is the high byte of every joined value
          cnt = {state_q.ch[hi].cnt, state_q.ch[lo].cnt};
          per = {state_d.ch[hi].per_act, state_d.ch[lo].per_act};
          dty = {state_d.ch[hi].dty_act, state_d.ch[lo].dty_act};
          cw  = cfg[hi].counter_write | cfg[lo].counter_write;
        end else begin
          if (s == 0)
            lo = hi;
          hi = lo;  // Lone channel: buffer loads touch only itself
          cnt = {8'h00, state_q.ch[lo].cnt};
          per = {8'h00, state_d.ch[lo].per_act};
          dty = {8'h00, state_d.ch[lo].dty_act};
          cw  = cfg[lo].counter_write;
        end
        // Odd slot steers a joined pair
        en  = cfg[lo].channel_enable;
        cae = cfg[lo].center_align_enable;
        pol = cfg[lo].polarity_select;
        tk  = clock_tick[lo] & en;
        dn  = state_q.ch[lo].dir_down;
        ff  = state_q.ch[lo].ff;
        if (cw) begin
          // Counter write: clear, count up, load buffers now
          cnt = 16'h0000;
          dn  = `PWMWC_DIR_UP;
          ff  = 1'b0;
          state_d.ch[lo].per_act = state_d.ch[lo].per_buf;
          state_d.ch[lo].dty_act = state_d.ch[lo].dty_buf;
          state_d.ch[hi].per_act = state_d.ch[hi].per_buf;
          state_d.ch[hi].dty_act = state_d.ch[hi].dty_buf;
        end else if (!en) begin
          // Disable: counter holds, buffers take effect
          state_d.ch[lo].per_act = state_d.ch[lo].per_buf;
          state_d.ch[lo].dty_act = state_d.ch[lo].dty_buf;
          state_d.ch[hi].per_act = state_d.ch[hi].per_buf;
          state_d.ch[hi].dty_act = state_d.ch[hi].dty_buf;
        end else if (tk && per == 16'h0000) begin
          cnt = 16'h0000;
          dn  = `PWMWC_DIR_UP;
        end else if (tk && !cae) begin
          // Left aligned: up only, reset at period
          if (cnt + 16'h0001 >= per) begin
            cnt = 16'h0000;
            ff  = 1'b0;
            state_d.ch[lo].per_act = state_d.ch[lo].per_buf;
            state_d.ch[lo].dty_act = state_d.ch[lo].dty_buf;
            state_d.ch[hi].per_act = state_d.ch[hi].per_buf;
            state_d.ch[hi].dty_act = state_d.ch[hi].dty_buf;
          end else begin
            cnt = cnt + 16'h0001;
            if (cnt == dty)
              ff = ~ff;
          end
          dn = `PWMWC_DIR_UP;
        end else if (tk) begin
          // Center aligned: up to period, back to zero
          if (cnt == 16'h0000)
            dn = `PWMWC_DIR_UP;
          if (!dn && cnt >= per)
            dn = 1'b1;
          cnt = dn ? cnt - 16'h0001 : cnt + 16'h0001;
          if (cnt == dty)
            ff = ~ff;
          if (dn && cnt == 16'h0000) begin
            dn = `PWMWC_DIR_UP;
            ff = 1'b0;
            state_d.ch[lo].per_act = state_d.ch[lo].per_buf;
            state_d.ch[lo].dty_act = state_d.ch[lo].dty_buf;
            state_d.ch[hi].per_act = state_d.ch[hi].per_buf;
            state_d.ch[hi].dty_act = state_d.ch[hi].dty_buf;
          end
        end
        state_d.ch[lo].cnt      = cnt[7:0];
        state_d.ch[lo].dir_down = dn;
        state_d.ch[lo].ff       = ff;
        if (join_bits[p]) begin
          state_d.ch[hi].cnt      = cnt[15:8];
          state_d.ch[hi].dir_down = `PWMWC_DIR_UP;
          state_d.ch[hi].ff       = 1'b0;
          state_d.out[hi]         = 1'b0;
        end
        // Disabled channel drives low; joined pin is the odd one
        state_d.out[lo] = en & level(per, dty, pol, ff);
      end
    end
    // Shutdown flag: set wins over clear
    state_d.sdn.pin_q = channel5_pin;
    state_d.sdn.arm_q = shutdown_arm_bit;
    if (shutdown_flag_clear)
      state_d.sdn.flag = 1'b0;
    if ((emergency_shutdown_enable &&
         channel5_pin != state_q.sdn.pin_q) ||
        (shutdown_arm_bit && !state_q.sdn.arm_q &&
         channel5_pin == channel5_active_level))
      state_d.sdn.flag = 1'b1;
  end

  // State register; counters start at zero counting up, all quiet
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // Outputs straight from flip-flops, except irq gated by shutdown_irq_enable
  always_comb begin
    for (int i = 0; i < `PWMWC_NUM_CH; i++)
      channel_counter[i] = state_q.ch[i].cnt;
  end
  assign channel_output    = state_q.out;
  assign shutdown_irq_flag = state_q.sdn.flag;
  assign irq               = state_q.sdn.flag & shutdown_irq_enable;

  // Checks
  property p_irq_gate;
    @(posedge clk) disable iff (!reset_n)
      irq |-> shutdown_irq_enable && shutdown_irq_flag;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without enable");

  property p_flag_set;
    @(posedge clk) disable iff (!reset_n)
      (emergency_shutdown_enable && $changed(channel5_pin))
      |=> shutdown_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set");

  property p_zero_period;
    @(posedge clk) disable iff (!reset_n)
      (!join_bits[0] && cfg[1].channel_enable && !cfg[1].counter_write &&
       !duty_write[1] && !period_write[1] &&
       state_q.ch[1].per_act == 8'h00) [*2]
      |-> channel_output[1] == cfg[1].polarity_select
          && state_q.ch[1].cnt == 8'h00;
  endproperty
  a_zero_period: assert property (p_zero_period)
    else $error("per0 level");

  property p_disabled_quiet;
    @(posedge clk) disable iff (!reset_n)
      !cfg[0].channel_enable && !join_bits[0] && !cfg[0].counter_write
      |=> $stable(state_q.ch[0].cnt);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("count stop");

  property p_cw_clear;
    @(posedge clk) disable iff (!reset_n)
      cfg[1].counter_write && !join_bits[0]
      |=> state_q.ch[1].cnt == 8'h00 && !state_q.ch[1].dir_down;
  endproperty
  a_cw_clear: assert property (p_cw_clear)
    else $error("cnt write");

  property p_joined_hi_off;
    @(posedge clk) disable iff (!reset_n)
      join_bits[0] |=> !channel_output[0];
  endproperty
  a_joined_hi_off: assert property (p_joined_hi_off)
    else $error("hi on");

  property p_left_bound;
    @(posedge clk) disable iff (!reset_n)
      !join_bits[0] && !cfg[1].center_align_enable &&
      state_q.ch[1].per_act != 8'h00 && cfg[1].channel_enable &&
      clock_tick[1] && !cfg[1].counter_write && !period_write[1]
      |=> state_q.ch[1].cnt < $past(state_q.ch[1].per_act);
  endproperty
  a_left_bound: assert property (p_left_bound)
    else $error("left range");

  property p_center_zero_up;
    @(posedge clk) disable iff (!reset_n)
      state_q.ch[1].cnt == 8'h00 && !join_bits[0]
      |-> !state_q.ch[1].dir_down ##1 (state_q.ch[1].cnt <= 8'h01);
  endproperty
  a_center_zero_up: assert property (p_center_zero_up)
    else $error("zero up");

  // Last count before the period wraps back to zero
  property p_left_wrap;
    @(posedge clk) disable iff (!reset_n)
      !join_bits[0] && !cfg[1].center_align_enable &&
      cfg[1].channel_enable && clock_tick[1] &&
      !cfg[1].counter_write && !period_write[1] &&
      state_q.ch[1].per_act != 8'h00 &&
      state_q.ch[1].cnt == state_q.ch[1].per_act - 8'h01
      |=> state_q.ch[1].cnt == 8'h00;
  endproperty
  a_left_wrap: assert property (p_left_wrap)
    else $error("left wrap");

  // Period one turns and lands on zero at once, so it is left out
  property p_center_turn;
    @(posedge clk) disable iff (!reset_n)
      !join_bits[0] && cfg[1].center_align_enable &&
      cfg[1].channel_enable && clock_tick[1] &&
      !cfg[1].counter_write && !period_write[1] &&
      state_q.ch[1].per_act > 8'h01 && !state_q.ch[1].dir_down &&
      state_q.ch[1].cnt == state_q.ch[1].per_act
      |=> state_q.ch[1].dir_down &&
          state_q.ch[1].cnt == $past(state_q.ch[1].cnt) - 8'h01;
  endproperty
  a_center_turn: assert property (p_center_turn)
    else $error("center turn");

  // Without a tick no load point comes, so the active duty must hold
  property p_duty_buffered;
    @(posedge clk) disable iff (!reset_n)
      duty_write[1] && cfg[1].channel_enable && !join_bits[0] &&
      !cfg[1].counter_write && !clock_tick[1]
      |=> state_q.ch[1].dty_act == $past(state_q.ch[1].dty_act);
  endproperty
  a_duty_buffered: assert property (p_duty_buffered)
    else $error("duty not buffered");

endmodule

// ===== logic/pwmwc_defines.svh
// Constants for the pwm channel waveform core
`ifndef PWMWC_DEFINES_SVH
`define PWMWC_DEFINES_SVH
`define PWMWC_NUM_CH     6
`define PWMWC_NUM_PAIRS  3
`define PWMWC_CNT_RESET  8'h00
`define PWMWC_DIR_UP     1'b0
`endif

// ===== logic/pwmwc_pkg.sv
// Types for the pwm channel waveform core
package pwmwc_pkg;
  // Per-channel programming from software
  typedef struct packed {
    logic [7:0] period_value;
    logic [7:0] duty_value;
    logic       channel_enable;
    logic       polarity_select;
    logic       center_align_enable;
    logic       counter_write;
  } pwmwc_cfg_t;
  // Per-channel live state
  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] per_act;
    logic [7:0] dty_act;
    logic [7:0] per_buf;
    logic [7:0] dty_buf;
    logic       dir_down;
    logic       ff;
  } pwmwc_ch_t;
  // Shutdown interrupt state
  typedef struct packed {
    logic pin_q;
    logic arm_q;
    logic flag;
  } pwmwc_sdn_t;
endpackage

// ===== sim/pwmwc_load.sv
// Load model counting high cycles and rising edges of one pin
`timescale 1ns/1ps
module pwmwc_load (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Watched pin and window restart
  input  wire logic        pin,
  input  wire logic        restart,
  // Counts since restart
  output logic      [15:0] high_q,
  output logic      [15:0] rise_q
);
  logic pin_q;
  // Whole periods in a window give phase-free counts
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {high_q, rise_q, pin_q} <= '0;
    end else if (restart) begin
      {high_q, rise_q} <= '0;
      pin_q <= pin;
    end else begin
      high_q <= high_q + 16'(pin);
      rise_q <= rise_q + 16'(pin & ~pin_q);
      pin_q  <= pin;
    end
  end
endmodule

// ===== sim/test_pwmwc_core.sv
// Self-checking bench for the waveform core
`timescale 1ns/1ps
module test_pwmwc_core
  import pwmwc_pkg::*;
  ;
  logic             clk, reset_n, restart, flag, irq;
  logic [5:0]       clock_tick, period_write, duty_write, channel_output;
  pwmwc_cfg_t [5:0] cfg;
  logic [2:0]       join_bits;
  logic             pin5, act5, sd_en, arm, irq_en, flag_clr;
  logic [7:0]       channel_counter [6];
  logic [15:0]      high_q, rise_q;
  int               errors, checks;
  // Boundary table: expected high, polarity, period, duty
  logic [17:0]      bnd [6] = '{18'h10400, 18'h20400, 18'h30002,
                                18'h00002, 18'h30404, 18'h00405};

  pwmwc_core dut (.clk(clk), .reset_n(reset_n), .clock_tick(clock_tick),
    .cfg(cfg), .period_write(period_write), .duty_write(duty_write),
    .join_bits(join_bits), .channel5_pin(pin5),
    .channel5_active_level(act5), .emergency_shutdown_enable(sd_en),
    .shutdown_arm_bit(arm), .shutdown_irq_enable(irq_en),
    .shutdown_flag_clear(flag_clr), .channel_output(channel_output),
    .channel_counter(channel_counter), .shutdown_irq_flag(flag),
    .irq(irq));
  pwmwc_load load (.clk(clk), .reset_n(reset_n),
    .pin(channel_output[1]), .restart(restart), .high_q(high_q),
    .rise_q(rise_q));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input string what, input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Program while disabled so values load straight, then restart counter
  task automatic prog(input int ch, input logic [7:0] per, dty,
                      input logic pol, cae, en);
    @(posedge clk);
    cfg[ch].channel_enable      <= 1'b0;
    cfg[ch].period_value        <= per;
    cfg[ch].duty_value          <= dty;
    cfg[ch].polarity_select     <= pol;
    cfg[ch].center_align_enable <= cae;
    period_write[ch]            <= 1'b1;
    duty_write[ch]              <= 1'b1;
    @(posedge clk);
    {period_write[ch], duty_write[ch]} <= 2'h0;
    cfg[ch].counter_write <= 1'b1;
    @(posedge clk);
    cfg[ch].counter_write  <= 1'b0;
    cfg[ch].channel_enable <= en;
  endtask

  // Let the waveform settle, then count over a whole number of periods
  task automatic measure(input string what, input int n,
                         input logic [15:0] hi, ri);
    cyc(20);
    restart <= 1'b1;
    cyc(1);
    restart <= 1'b0;
    cyc(n);
    #1;
    check({what, " high"}, hi, high_q);
    check({what, " rises"}, ri, rise_q);
    $display("test %s done", what);
  endtask

  initial begin
    cyc(20000);
    errors++;
    print_verdict();
  end

  initial begin
    {reset_n, restart, period_write, duty_write, join_bits} = '0;
    {pin5, sd_en, arm, irq_en, flag_clr} = 5'h00;
    cfg = '0;
    clock_tick = 6'h3F;
    act5 = 1'b1;
    errors = 0;
    checks = 0;
    cyc(12);
    reset_n <= 1'b1;
    cyc(5);
    #1;
    check("reset outputs", 16'h0000, {10'h000, channel_output});
    check("reset counter", 16'h0000, {8'h00, channel_counter[1]});
    $display("test reset done");
    prog(1, 8'h04, 8'h01, 1'b0, 1'b0, 1'b1);
    measure("left pol0", 40, 16'h001E, 16'h000A);
    prog(1, 8'h04, 8'h01, 1'b1, 1'b0, 1'b1);
    measure("left pol1", 40, 16'h000A, 16'h000A);
    prog(1, 8'h04, 8'h01, 1'b0, 1'b1, 1'b1);
    measure("center pol0", 40, 16'h001E, 16'h0005);
    prog(1, 8'h04, 8'h01, 1'b1, 1'b1, 1'b1);
    measure("center pol1", 40, 16'h000A, 16'h0005);
    // Constant levels, alternating alignment
    foreach (bnd[i]) begin
      prog(1, bnd[i][15:8], bnd[i][7:0], bnd[i][16], i[0], 1'b1);
      measure("bound", 40, bnd[i][17] ? 16'h0028 : 16'h0000,
              16'h0000);
      if (bnd[i][15:8] == 8'h00)
        check("held counter", 16'h0000,
              {8'h00, channel_counter[1]});
    end
    // Ticks stopped so only buffer loads can move the output
    cyc(1);
    clock_tick <= 6'h00;
    prog(1, 8'h04, 8'h02, 1'b1, 1'b0, 1'b1);
    cyc(3);
    #1;
    check("start level", 16'h0001,
          {15'h0000, channel_output[1]});
    cyc(1);
    cfg[1].duty_value <= 8'h00;
    duty_write[1] <= 1'b1;
    cyc(1);
    duty_write[1] <= 1'b0;
    cyc(3);
    #1;
    check("buffered duty", 16'h0001, {15'h0000, channel_output[1]});
    cyc(1);
    cfg[1].counter_write <= 1'b1;
    cyc(1);
    cfg[1].counter_write <= 1'b0;
    cyc(3);
    #1;
    check("loaded duty", 16'h0000,
          {15'h0000, channel_output[1]});
    $display("test buffer done");
    // Join 0/1: even channel's enable, polarity and alignment ignored
    prog(1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0);
    clock_tick <= 6'h3F;
    join_bits <= 3'h1;
    prog(0, 8'h01, 8'h00, 1'b1, 1'b1, 1'b1);
    prog(1, 8'h00, 8'h40, 1'b0, 1'b0, 1'b1);
    measure("joined", 512, 16'h0180, 16'h0002);
    check("even output", 16'h0000, {15'h0000, channel_output[0]});
    cyc(1);
    clock_tick <= 6'h00;
    cfg[0].counter_write <= 1'b1;
    cyc(1);
    cfg[0].counter_write <= 1'b0;
    cyc(2);
    #1;
    check("joined clear", 16'h0000,
          {channel_counter[0], channel_counter[1]});
    // Shutdown flag and interrupt gating
    cyc(1);
    sd_en <= 1'b1;
    cyc(2);
    pin5 <= 1'b1;
    cyc(3);
    #1;
    check("pin flag", 16'h0001, {15'h0000, flag});
    check("irq masked", 16'h0000, {15'h0000, irq});
    cyc(1);
    irq_en <= 1'b1;
    cyc(2);
    #1;
    check("irq on", 16'h0001, {15'h0000, irq});
    cyc(1);
    {flag_clr, sd_en} <= 2'h2;
    cyc(1);
    {flag_clr, pin5} <= 2'h0;
    cyc(2);
    pin5 <= 1'b1;
    cyc(3);
    #1;
    check("no flag", 16'h0000, {15'h0000, flag});
    check("irq clear", 16'h0000, {15'h0000, irq});
    cyc(1);
    arm <= 1'b1;
    cyc(3);
    #1;
    check("arm flag", 16'h0001, {15'h0000, flag});
    // Arming while the pin sits at its inactive level must stay quiet
    cyc(1);
    {flag_clr, arm, act5} <= 3'h4;
    cyc(1);
    flag_clr <= 1'b0;
    cyc(2);
    arm <= 1'b1;
    cyc(3);
    #1;
    check("inactive arm", 16'h0000, {15'h0000, flag});
    $display("test shutdown done");
    print_verdict();
  end
endmodule
